// >>> tsip_port.sv
`timescale 1ns/1ns
`default_nettype none
`include "tsip_params.svh"
module tsip_port
  import tsip_pkg::*;
#(
  parameter int unsigned STALL_CYC = `TSIP_STALL_CYC,
  parameter int unsigned HOLD_CYC = `TSIP_HOLD_CYC
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // serial bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // address straps, already resolved with their pull-downs
  input wire logic addr_strap_bit0,
  input wire logic addr_strap_bit1,
  input wire logic addr_strap_bit2,
  // alert pin
  input wire logic temp_out_of_limit,
  output logic alert_o,
  output logic alert_oe,
  // register side
  input wire logic [7:0] rd_data,
  output logic [7:0] ptr_q,
  output logic [7:0] wr_data_q,
  output logic wr_stb_q,
  output logic rd_stb_q
);
  logic scl_f;
  logic sda_f;
  logic scl_p_q;
  logic sda_p_q;
  logic [2:0] strap_m_q;
  logic [2:0] strap_q;
  tsip_state_t st_q;
  logic [3:0] bit_q;
  logic [7:0] sh_q;
  logic rd_q;
  logic ptr_ph_q;
  logic nack_q;
  logic ack_own_q;
  logic [31:0] stall_q;
  logic [7:0] hold_q;
  logic pend_q;
  logic pend_v_q;
  logic timeout;

  // filtered, synchronised copies of scl and sda
  tsip_filt u_scl (.mclk(mclk), .rst(rst), .pin_i(scl_i), .level_q(scl_f));
  tsip_filt u_sda (.mclk(mclk), .rst(rst), .pin_i(sda_i), .level_q(sda_f));

  // previous filtered levels for edge finding
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end
    else
    begin
      scl_p_q <= scl_f;
      sda_p_q <= sda_f;
    end
  end

  wire scl_rise = scl_f & ~scl_p_q;
  wire scl_fall = ~scl_f & scl_p_q;
  wire start_c = scl_f & scl_p_q & sda_p_q & ~sda_f;
  wire stop_c = scl_f & scl_p_q & ~sda_p_q & sda_f;

  // straps are pins too, so they pass two flops
  always_ff @(posedge mclk)
  begin
    strap_m_q <= {addr_strap_bit2, addr_strap_bit1, addr_strap_bit0};
    strap_q <= strap_m_q;
  end

  // stall counter, mclk based; restarts on every scl edge
  always_ff @(posedge mclk)
  begin
    if (rst || scl_f != scl_p_q || st_q == TSIP_IDLE)
      stall_q <= 32'h0;
    else if (!scl_f && stall_q < STALL_CYC)
      stall_q <= stall_q + 32'h1;
  end
  assign timeout = !scl_f && (stall_q >= STALL_CYC);

  // protocol sequencer; samples sda on scl rise, i.e. while high
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      st_q <= TSIP_IDLE;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      rd_q <= 1'b0;
      ptr_ph_q <= 1'b0;
      nack_q <= 1'b0;
      ack_own_q <= 1'b0;
      ptr_q <= 8'h00;
      wr_data_q <= 8'h00;
      wr_stb_q <= 1'b0;
      rd_stb_q <= 1'b0;
    end
    else
    begin
      wr_stb_q <= 1'b0;
      rd_stb_q <= 1'b0;
      if (timeout || stop_c)
        st_q <= TSIP_IDLE;
      else if (start_c)
      begin
        // repeated start abandons the current byte
        st_q <= TSIP_ADDR;
        bit_q <= 4'h0;
      end
      else if (scl_rise)
      begin
        unique case (st_q)
          TSIP_IDLE: ;
          TSIP_ADDR, TSIP_RECV:
          begin
            sh_q <= {sh_q[6:0], sda_f};
            bit_q <= bit_q + 4'h1;
          end
          TSIP_SEND:
            bit_q <= bit_q + 4'h1;
          TSIP_ACK:
            nack_q <= sda_f;
        endcase
      end
      else if (scl_fall)
      begin
        unique case (st_q)
          TSIP_IDLE: ;
          TSIP_ADDR:
            if (bit_q == 4'h8)
            begin
              if (sh_q[7:1] == {`TSIP_ADDR_FIXED, strap_q})
              begin
                st_q <= TSIP_ACK;
                ack_own_q <= 1'b1; // address ack is ours, read or write
                rd_q <= sh_q[0];
                ptr_ph_q <= ~sh_q[0];
                if (sh_q[0])
                  rd_stb_q <= 1'b1;
              end
              else
                st_q <= TSIP_IDLE;
              bit_q <= 4'h0;
            end
          TSIP_RECV:
            if (bit_q == 4'h8)
            begin
              if (ptr_ph_q)
                ptr_q <= sh_q;
              else
              begin
                wr_data_q <= sh_q;
                wr_stb_q <= 1'b1;
              end
              ptr_ph_q <= 1'b0;
              ack_own_q <= 1'b1;
              st_q <= TSIP_ACK;
              bit_q <= 4'h0;
            end
          TSIP_SEND:
            if (bit_q == 4'h8)
            begin
              ack_own_q <= 1'b0; // controller answers read data
              st_q <= TSIP_ACK;
              bit_q <= 4'h0;
            end
          TSIP_ACK:
            if (rd_q && nack_q)
              st_q <= TSIP_IDLE; // nak ends a read, sda left free for stop
            else if (rd_q)
            begin
              st_q <= TSIP_SEND;
              sh_q <= rd_data;
            end
            else
              st_q <= TSIP_RECV;
        endcase
      end
    end
  end

  // sda update held off HOLD_CYC after scl falls HOLD_CYC is far
  // below the 1250 ns deadline, so the bit is out in time
  always_ff @(posedge mclk)
  begin
    if (rst || scl_rise || timeout || start_c || stop_c)
      hold_q <= 8'h00;
    else if (scl_fall)
      hold_q <= 8'(HOLD_CYC);
    else if (hold_q != 8'h00)
      hold_q <= hold_q - 8'h01;
  end

  // what the line should show once the hold expires
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      pend_q <= 1'b0;
      pend_v_q <= 1'b0;
    end
    else
    begin
      pend_v_q <= scl_fall;
      if (pend_v_q)
      begin
        unique case (st_q)
          TSIP_ACK: pend_q <= 1'b0;
          TSIP_SEND: pend_q <= ~sh_q[3'h7 - bit_q[2:0]];
          default: pend_q <= 1'b0;
        endcase
      end
    end
  end

  // open-drain sda: only ever drives low scl is never driven
  always_ff @(posedge mclk)
  begin
    if (rst || timeout || start_c || stop_c || st_q == TSIP_IDLE)
    begin
      sda_oe <= 1'b0;
      sda_o <= 1'b0;
    end
    else if (hold_q == 8'h01 || (HOLD_CYC == 0 && pend_v_q))
    begin
      // own ack slot, else the pending data bit
      sda_oe <= (st_q == TSIP_ACK && ack_own_q) || (st_q == TSIP_SEND && pend_q);
      sda_o <= 1'b0;
    end
  end

  // alert pin: pull low while out of limit, else release
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      alert_oe <= 1'b0;
      alert_o <= 1'b0;
    end
    else
    begin
      alert_oe <= temp_out_of_limit;
      alert_o <= 1'b0;
    end
  end
endmodule : tsip_port
`default_nettype wire

// >>> tsip_params.svh
`ifndef TSIP_PARAMS_SVH
`define TSIP_PARAMS_SVH
// clock rate in kHz
`define TSIP_MCLK_KHZ 100000
// fixed upper address nibble, msb first 0,0,1,1
`define TSIP_ADDR_FIXED 4'h3
// bus stall limit, ms; 30 ms sits inside the 25..35 ms window
`define TSIP_STALL_MS 30
`define TSIP_STALL_CYC (`TSIP_STALL_MS * `TSIP_MCLK_KHZ)
// transmit bit hold delay after scl fall, ns (rounded up to cycles)
`define TSIP_HOLD_NS 200
`define TSIP_HOLD_CYC ((`TSIP_HOLD_NS * `TSIP_MCLK_KHZ + 999999) / 1000000)
// latest bit output: rise max plus setup min, ns
`define TSIP_SETUP_NS 1250
`define TSIP_SETUP_CYC ((`TSIP_SETUP_NS * `TSIP_MCLK_KHZ) / 1000000)
// glitch suppression window, ns (rounded up to cycles)
`define TSIP_SPIKE_NS 50
`define TSIP_SPIKE_CYC ((`TSIP_SPIKE_NS * `TSIP_MCLK_KHZ + 999999) / 1000000)
`endif

// >>> tsip_pkg.sv
package tsip_pkg;
  typedef enum logic [4:0] {
    TSIP_IDLE = 5'h01,
    TSIP_ADDR = 5'h02,
    TSIP_RECV = 5'h04,
    TSIP_SEND = 5'h08,
    TSIP_ACK = 5'h10
  } tsip_state_t;
endpackage : tsip_pkg

// >>> tsip_filt.sv
`timescale 1ns/1ns
`default_nettype none
`include "tsip_params.svh"
// two-flop synchroniser followed by a stability filter
module tsip_filt #(
  parameter int unsigned CYC = `TSIP_SPIKE_CYC
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // raw pin and clean level
  input wire logic pin_i,
  output logic level_q
);
  logic meta_q;
  logic sync_q;
  logic [3:0] cnt_q;

  // first flop feeds only the second
  always_ff @(posedge mclk)
  begin
    meta_q <= pin_i;
    sync_q <= meta_q;
  end

  // level follows only after the input has been steady for CYC + 1 cycles
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      level_q <= 1'b1;
      cnt_q <= 4'h0;
    end
    else if (sync_q == level_q)
      cnt_q <= 4'h0;
    else if (cnt_q >= 4'(CYC))
    begin
      level_q <= sync_q;
      cnt_q <= 4'h0;
    end
    else
      cnt_q <= cnt_q + 4'h1;
  end
endmodule : tsip_filt
`default_nettype wire

// >>> tsip_port_sva.sv
`timescale 1ns/1ns
`default_nettype none
// port checks, serial side and alert pin
module tsip_port_sva #(
  parameter int unsigned STALL_CYC = 2000
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // watched ports
  input wire logic scl_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic temp_out_of_limit,
  input wire logic alert_o,
  input wire logic alert_oe,
  input wire logic [7:0] ptr_q,
  input wire logic wr_stb_q,
  input wire logic rd_stb_q
);
  // raw scl low time; saturates so it never wraps
  logic [31:0] low_q;
  always_ff @(posedge mclk)
  begin
    if (rst || scl_i)
      low_q <= 32'h0;
    else if (!(&low_q))
      low_q <= low_q + 32'h1;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  a_sda_pull_only: assert property (sda_o == 1'b0)
    else $error("sda high");
  a_alert_pull_only: assert property (alert_o == 1'b0)
    else $error("alert high");
  a_alert_follows: assert property ($changed(temp_out_of_limit) |-> ##[1:4]
    alert_oe == temp_out_of_limit) else $error("alert lag");
  a_tx_bit_hold: assert property ($fell(scl_i) |=> $stable(sda_oe) [*2])
    else $error("sda hold short");
  a_tx_hold_span: assert property (!scl_i && $changed(sda_oe) |->
    low_q >= 20) else $error("sda moved inside hold");
  a_tx_setup_time: assert property (!scl_i && $changed(sda_oe) |->
    low_q <= 125 || low_q >= STALL_CYC) else $error("sda late");
  a_stall_release: assert property (low_q > STALL_CYC + 20 |-> !sda_oe)
    else $error("stall kept sda");
  a_wr_one_pulse: assert property (wr_stb_q |=> !wr_stb_q)
    else $error("write strobe long");
  a_rd_one_pulse: assert property (rd_stb_q |=> !rd_stb_q)
    else $error("read strobe long");
  a_ptr_on_data: assert property (wr_stb_q |-> $stable(ptr_q))
    else $error("pointer moved");
  c_write: cover property (wr_stb_q);
  c_read: cover property (rd_stb_q);
  c_drive: cover property ($rose(sda_oe));
  c_stall: cover property (low_q > STALL_CYC);
endmodule : tsip_port_sva
bind tsip_port tsip_port_sva #(.STALL_CYC(STALL_CYC)) tsip_port_sva_inst (.mclk(mclk),
  .rst(rst), .scl_i(scl_i), .sda_o(sda_o), .sda_oe(sda_oe), .alert_o(alert_o),
  .temp_out_of_limit(temp_out_of_limit), .alert_oe(alert_oe), .ptr_q(ptr_q),
  .wr_stb_q(wr_stb_q), .rd_stb_q(rd_stb_q));
`default_nettype wire

// >>> tsip_host.sv
`timescale 1ns/1ns
`default_nettype none
// bus controller; scl stands high between frames
module tsip_host (
  // resolved data level
  input wire logic sda_line,
  // clock and data pull-down
  output var logic scl,
  output var logic sda_low
);
  // fastest legal rate; filter lag plus hold need most of the low phase
  localparam int HALF = 500;
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // 3 ns offset keeps link edges off mclk edges
  task automatic start_c();
    #3;
    sda_low = 1'b0;
    #(HALF) scl = 1'b1;
    #(HALF) sda_low = 1'b1;
    #(HALF) scl = 1'b0;
  endtask : start_c
  task automatic stop_c();
    sda_low = 1'b1;
    #(HALF) scl = 1'b1;
    #(HALF) sda_low = 1'b0;
    #(HALF);
  endtask : stop_c
  // data moves at once after scl falls
  task automatic bit_c(input logic b, output logic r);
    sda_low = !b;
    #(HALF) scl = 1'b1;
    #(HALF / 2) r = sda_line;
    #(HALF / 2) scl = 1'b0;
  endtask : bit_c
  task automatic byte_c(input logic [7:0] d, input logic a, output logic [7:0] q,
    output logic k);
    for (int i = 7; i >= 0; i--)
      bit_c(d[i], q[i]);
    bit_c(a, k);
  endtask : byte_c
endmodule : tsip_host
`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  // short stall limit keeps the run brief
  localparam int unsigned STALL = 2000;
  logic mclk;
  logic rst = 1'b1;
  logic temp = 1'b0;
  logic [7:0] rd_data = 8'h00;
  logic [2:0] strap_drv = 3'bzzz;
  logic [7:0] q;
  logic ak;
  logic [7:0] lfsr_q = 8'h09;
  int failures = 0;
  int checked = 0;
  tri0 [2:0] strap_pin;
  wire logic scl, sda_low, sda_line, sda_o, sda_oe, alert_oe;
  wire logic [7:0] ptr, wdat;
  // pulled-up wired-and data line
  assign sda_line = !(sda_low || (sda_oe && !sda_o));
  assign strap_pin = strap_drv;
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  tsip_port #(.STALL_CYC(STALL)) tsip_port_inst (.mclk(mclk), .rst(rst), .scl_i(scl),
    .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe), .addr_strap_bit0(strap_pin[0]),
    .addr_strap_bit1(strap_pin[1]), .addr_strap_bit2(strap_pin[2]), .alert_o(),
    .temp_out_of_limit(temp), .alert_oe(alert_oe), .rd_data(rd_data), .ptr_q(ptr),
    .wr_data_q(wdat), .wr_stb_q(), .rd_stb_q());
  tsip_host tsip_host_inst (.sda_line(sda_line), .scl(scl), .sda_low(sda_low));
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  function automatic logic ack_exp(input logic [6:0] a, input logic [2:0] s);
    return (a === {4'h3, s}) ? 1'b0 : 1'b1;
  endfunction : ack_exp
  task automatic check(input string n, input logic [7:0] seen, input logic [7:0] want);
    checked++;
    if (seen !== want)
    begin
      failures++;
      $display("[ERR] %s exp %h seen %h", n, want, seen);
    end
  endtask : check
  task automatic results();
    if (failures == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : results
  task automatic wr_txn(input logic [6:0] a, input logic [2:0] s, input logic [7:0] p);
    tsip_host_inst.start_c();
    tsip_host_inst.byte_c({a, 1'b0}, 1'b1, q, ak);
    check("ack", 8'(ak), 8'(ack_exp(a, s)));
    if (!ack_exp(a, s))
    begin
      tsip_host_inst.byte_c(p, 1'b1, q, ak);
      tsip_host_inst.byte_c(~p, 1'b1, q, ak);
      check("ptr", ptr, p);
      check("wdata", wdat, ~p);
    end
    tsip_host_inst.stop_c();
  endtask : wr_txn
  // read, controller naks; pointer must survive
  task automatic rd_txn(input logic [6:0] a, input logic [7:0] p);
    tsip_host_inst.start_c();
    tsip_host_inst.byte_c({a, 1'b1}, 1'b1, q, ak);
    check("rd ack", 8'(ak), 8'h00);
    tsip_host_inst.byte_c(8'hFF, 1'b1, q, ak);
    tsip_host_inst.stop_c();
    check("rdata", q, rd_data);
    check("ptr kept", ptr, p);
  endtask : rd_txn
  initial
  begin
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    repeat (4) @(posedge mclk);
    for (int k = 0; k < 8; k++)
    begin
      lfsr_q = lfsr(lfsr_q);
      @(posedge mclk);
      strap_drv <= (k == 0) ? 3'bzzz : 3'(k);
      rd_data <= lfsr_q;
      temp <= lfsr_q[0];
      wr_txn({4'h3, 3'(k)}, 3'(k), lfsr_q);
      wr_txn({4'h2, 3'(k)}, 3'(k), 8'h00);
      wr_txn({4'h3, 3'(k ^ 5)}, 3'(k), 8'h00);
      rd_txn({4'h3, 3'(k)}, lfsr_q);
      check("alert", 8'(alert_oe), 8'(temp));
    end
    // stop four bits into the pointer byte
    tsip_host_inst.start_c();
    tsip_host_inst.byte_c(8'h3E, 1'b1, q, ak);
    check("abandon ack", 8'(ak), 8'h00);
    for (int i = 0; i < 4; i++)
      tsip_host_inst.bit_c(1'b0, ak);
    tsip_host_inst.stop_c();
    check("abandon", 8'(sda_oe), 8'h00);
    rd_txn(7'h1F, lfsr_q);
    // scl held low while the device drives a zero
    @(posedge mclk);
    rd_data <= 8'h00;
    tsip_host_inst.start_c();
    tsip_host_inst.byte_c(8'h3F, 1'b1, q, ak);
    #(STALL * 7);
    check("early drop", 8'(sda_oe), 8'h01);
    #(STALL * 6);
    check("stall drop", 8'(sda_oe), 8'h00);
    tsip_host_inst.stop_c();
    wr_txn(7'h1F, 3'h7, 8'hA5);
    results();
  end
  // hang guard, well past the expected run
  initial
  begin
    #900000;
    failures++;
    results();
  end
endmodule : tb_top
`default_nettype wire
